// ==== byte_alu_pkg.sv ====
// package: offsets, reset values, field positions and opcodes of the byte alu
`default_nettype none
package byte_alu_pkg;
	// ******************************************
	// register byte offsets on apb
	// ******************************************
	localparam logic [7:0] off_ctrl = 8'h00;
	localparam logic [7:0] off_instr = 8'h04;
	localparam logic [7:0] off_w = 8'h08;
	localparam logic [7:0] off_status = 8'h0c;
	localparam logic [7:0] off_bank = 8'h10;
	localparam logic [7:0] off_index = 8'h14;
	localparam logic [7:0] off_ram_addr = 8'h18;
	localparam logic [7:0] off_ram_data = 8'h1c;
	localparam logic [7:0] off_exec = 8'h20;
	// ******************************************
	// field positions
	// ******************************************
	localparam int ext_bit = 6;
	localparam int two_word_bit = 0;
	localparam int flag_c = 0;
	localparam int flag_dc = 1;
	localparam int flag_z = 2;
	localparam int flag_ov = 3;
	localparam int flag_n = 4;
	localparam int dest_bit = 9;
	localparam int access_bit = 8;
	// ******************************************
	// reset values and limits
	// ******************************************
	localparam logic [7:0] ctrl_reset = 8'h00;
	localparam logic [7:0] indexed_limit = 8'h5f;
	localparam logic [7:0] access_split = 8'h80;
	localparam logic [3:0] access_high_bank = 4'hf;
	// ******************************************
	// opcode prefixes
	// ******************************************
	localparam logic [5:0] op_add_w_carry_to_file = 6'h08;
	localparam logic [5:0] op_complement_file = 6'h07;
	localparam logic [6:0] op_compare_skip_if_equal = 7'h31;
	localparam logic [7:0] op_and_literal_into_w = 8'h0b;
	typedef enum logic [2:0] {
		s_idle = 3'b000,
		s_fetch = 3'b001,
		s_exec = 3'b010,
		s_skip1 = 3'b011,
		s_skip2 = 3'b100
	} exec_state_t;
endpackage : byte_alu_pkg
`default_nettype wire

// ==== ram_if.sv ====
// interface: data memory port between the core datapath and its ram
`default_nettype none
interface ram_if #(parameter int aw = 12);
	logic [aw-1:0] addr;
	logic [7:0] wdata;
	logic we;
	logic [7:0] rdata;
	modport ctl(output addr, output wdata, output we, input rdata);
	modport mem(input addr, input wdata, input we, output rdata);
endinterface : ram_if
`default_nettype wire

// ==== data_ram.sv ====
// module: general purpose data ram, registered read
`default_nettype none
module data_ram #(parameter int aw = 12) (
	input wire logic ref_clk,
	ram_if.mem port
);
	logic [7:0] mem [0:(1<<aw)-1];
	// ******************************************
	// write and registered read
	// ******************************************
	always_ff @(posedge ref_clk) begin
		if (port.we) begin
			mem[port.addr] <= port.wdata;
		end
		port.rdata <= mem[port.addr];
	end
endmodule : data_ram
`default_nettype wire

// ==== byte_alu.sv ====
// module: byte alu datapath for four instructions, apb register access
//
// Design decisions made here: the APB register port and the register offsets.
`default_nettype none
// Notes on behaviour
// RULE1 - add w, carry and byte; update five flags
// RULE2 - destination bit 0 to w, 1 to file
// RULE3 - access bit: access bank or bank register
// RULE4 - extended, a=0, f<=95: indexed literal offset
// RULE5 - complement byte; only negative and zero flags
// RULE6 - compare unsigned, store nothing, flags untouched
// RULE7 - equal: skip, two or three cycles
// RULE8 - bit 6 enables extended set
// RULE9 - and literal into w; negative, zero only
module byte_alu #(parameter int aw = 12) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	ram_if #(.aw(aw)) ram();
	data_ram #(.aw(aw)) u_ram(.ref_clk(ref_clk), .port(ram));

	// ******************************************
	// state
	// ******************************************
	byte_alu_pkg::exec_state_t state;
	logic [7:0] ctrl;
	logic [15:0] instr;
	logic [7:0] w;
	logic [7:0] status;
	logic [3:0] bank_select_reg;
	logic [aw-1:0] index_reg;
	logic [aw-1:0] ram_addr;
	logic [aw-1:0] exec_addr;
	logic [1:0] cycles;
	logic skipped;
	logic [7:0] addr_low;
	logic wr;
	logic rd_ok;
	logic launch;
	logic [7:0] f_val;
	logic [7:0] result;
	logic [7:0] next_status;
	logic is_add;
	logic is_comp;
	logic is_cmp;
	logic is_and;
	logic uses_file;

	function automatic logic [aw-1:0] file_addr(
		input logic [15:0] ins,
		input logic ext,
		input logic [3:0] bsel,
		input logic [aw-1:0] idx
	);
		logic [7:0] f;
		f = ins[7:0];
		if (ins[byte_alu_pkg::access_bit]) begin
			file_addr = aw'({bsel, f}); // [RULE3]
		end else if (ext && f <= byte_alu_pkg::indexed_limit) begin
			file_addr = idx + aw'(f); // [RULE4]
		end else if (f < byte_alu_pkg::access_split) begin
			file_addr = aw'(f); // [RULE3]
		end else begin
			file_addr = aw'({byte_alu_pkg::access_high_bank, f});
		end
	endfunction : file_addr

	// ******************************************
	// apb decode
	// ******************************************
	assign addr_low = paddr[7:0];
	assign pready = (state == byte_alu_pkg::s_idle);
	// refused address must not alias a register through its low byte
	assign wr = psel && penable && pwrite && pready && rd_ok;
	assign launch = wr && addr_low == byte_alu_pkg::off_instr;

	always_comb begin
		rd_ok = 1'b1;
		prdata = 32'h0;
		if (paddr[31:8] != 24'h0) begin
			rd_ok = 1'b0;
		end else if (addr_low == byte_alu_pkg::off_ctrl) begin
			prdata = {24'h0, ctrl};
		end else if (addr_low == byte_alu_pkg::off_instr) begin
			prdata = {16'h0, instr};
		end else if (addr_low == byte_alu_pkg::off_w) begin
			prdata = {24'h0, w};
		end else if (addr_low == byte_alu_pkg::off_status) begin
			prdata = {24'h0, status};
		end else if (addr_low == byte_alu_pkg::off_bank) begin
			prdata = {28'h0, bank_select_reg};
		end else if (addr_low == byte_alu_pkg::off_index) begin
			prdata = 32'(index_reg);
		end else if (addr_low == byte_alu_pkg::off_ram_addr) begin
			prdata = 32'(ram_addr);
		end else if (addr_low == byte_alu_pkg::off_ram_data) begin
			prdata = {24'h0, ram.rdata};
		end else if (addr_low == byte_alu_pkg::off_exec) begin
			prdata = {26'h0, cycles, 2'b00, skipped, 1'b0};
		end else begin
			rd_ok = 1'b0;
		end
	end
	assign pslverr = psel && penable && !rd_ok;

	// ******************************************
	// software registers
	// ******************************************
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ctrl <= byte_alu_pkg::ctrl_reset;
			bank_select_reg <= 4'h0;
			index_reg <= '0;
			ram_addr <= '0;
		end else if (wr) begin
			if (addr_low == byte_alu_pkg::off_ctrl) begin
				ctrl <= pwdata[7:0] & 8'h41; // [RULE8]
			end
			if (addr_low == byte_alu_pkg::off_bank) begin
				bank_select_reg <= pwdata[3:0];
			end
			if (addr_low == byte_alu_pkg::off_index) begin
				index_reg <= pwdata[aw-1:0];
			end
			if (addr_low == byte_alu_pkg::off_ram_addr) begin
				ram_addr <= pwdata[aw-1:0];
			end
		end
	end

	// ******************************************
	// decode and alu
	// ******************************************
	assign is_add = instr[15:10] == byte_alu_pkg::op_add_w_carry_to_file;
	assign is_comp = instr[15:10] == byte_alu_pkg::op_complement_file;
	assign is_cmp = instr[15:9] == byte_alu_pkg::op_compare_skip_if_equal;
	assign is_and = instr[15:8] == byte_alu_pkg::op_and_literal_into_w;
	assign uses_file = is_add || is_comp;
	assign f_val = ram.rdata;

	always_comb begin
		logic [8:0] sum;
		logic [4:0] low;
		sum = 9'h0;
		low = 5'h0;
		result = 8'h0;
		next_status = status;
		if (is_add) begin
			sum = {1'b0, w} + {1'b0, f_val} + {8'h0, status[byte_alu_pkg::flag_c]};
			low = {1'b0, w[3:0]} + {1'b0, f_val[3:0]}
				+ {4'h0, status[byte_alu_pkg::flag_c]};
			result = sum[7:0];
			next_status[byte_alu_pkg::flag_c] = sum[8]; // [RULE1]
			next_status[byte_alu_pkg::flag_dc] = low[4]; // [RULE1]
			next_status[byte_alu_pkg::flag_ov] = (w[7] == f_val[7])
				&& (sum[7] != w[7]); // [RULE1]
			next_status[byte_alu_pkg::flag_z] = (sum[7:0] == 8'h0);
			next_status[byte_alu_pkg::flag_n] = sum[7];
		end else if (is_comp) begin
			result = ~f_val; // [RULE5]
			next_status[byte_alu_pkg::flag_z] = (result == 8'h0);
			next_status[byte_alu_pkg::flag_n] = result[7];
		end else if (is_and) begin
			result = w & instr[7:0]; // [RULE9]
			next_status[byte_alu_pkg::flag_z] = (result == 8'h0);
			next_status[byte_alu_pkg::flag_n] = result[7];
		end
	end

	// ******************************************
	// ram port: apb owns it only while idle
	// ******************************************
	assign ram.addr = (state == byte_alu_pkg::s_idle) ? ram_addr : exec_addr;
	assign ram.wdata = (state == byte_alu_pkg::s_exec) ? result
		: pwdata[7:0];
	assign ram.we = (state == byte_alu_pkg::s_exec)
		? (uses_file && instr[byte_alu_pkg::dest_bit]) // [RULE2]
		: (wr && addr_low == byte_alu_pkg::off_ram_data);

	// ******************************************
	// execution sequence
	// ******************************************
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state <= byte_alu_pkg::s_idle;
			instr <= 16'h0;
			exec_addr <= '0;
		end else begin
			case (state)
				byte_alu_pkg::s_idle: begin
					if (launch) begin
						instr <= pwdata[15:0];
						exec_addr <= file_addr(pwdata[15:0],
							ctrl[byte_alu_pkg::ext_bit], bank_select_reg,
							index_reg); // [RULE8]
						state <= (pwdata[15:8] == byte_alu_pkg::op_and_literal_into_w)
							? byte_alu_pkg::s_exec : byte_alu_pkg::s_fetch;
					end
				end
				byte_alu_pkg::s_fetch: begin
					state <= byte_alu_pkg::s_exec;
				end
				byte_alu_pkg::s_exec: begin
					// equal compare goes on to s_skip1 instead of back to s_idle
					if (is_cmp && f_val == w) begin
						state <= byte_alu_pkg::s_skip1; // [RULE7]
					end else begin
						state <= byte_alu_pkg::s_idle;
					end
				end
				byte_alu_pkg::s_skip1: begin
					state <= ctrl[byte_alu_pkg::two_word_bit]
						? byte_alu_pkg::s_skip2 : byte_alu_pkg::s_idle; // [RULE7]
				end
				default: begin
					state <= byte_alu_pkg::s_idle;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			w <= 8'h0;
			status <= 8'h0;
		end else if (state == byte_alu_pkg::s_exec) begin
			// compare leaves w and all flags alone
			if (!is_cmp) begin
				status <= next_status; // [RULE6]
			end
			if (is_and || (uses_file && !instr[byte_alu_pkg::dest_bit])) begin
				w <= result; // [RULE2]
			end
		end else if (wr && addr_low == byte_alu_pkg::off_w) begin
			w <= pwdata[7:0];
		end else if (wr && addr_low == byte_alu_pkg::off_status) begin
			status <= pwdata[7:0] & 8'h1f;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cycles <= 2'd0;
			skipped <= 1'b0;
		end else if (state == byte_alu_pkg::s_exec) begin
			cycles <= 2'd1;
			skipped <= is_cmp && f_val == w; // [RULE6]
		end else if (state == byte_alu_pkg::s_skip1
			|| state == byte_alu_pkg::s_skip2) begin
			cycles <= cycles + 2'd1; // [RULE7]
		end
	end
endmodule : byte_alu
`default_nettype wire

// ==== byte_alu_props.sv ====
// checker: port-level timing and read-back properties of the byte alu
`default_nettype none
module byte_alu_props (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	logic go;
	logic rd;
	logic [7:0] op;
	// instruction word taken only when the engine is idle
	assign go = psel && penable && pready && pwrite && paddr == 32'h4;
	assign rd = psel && penable && !pwrite;
	assign op = pwdata[15:8];
	chk_and_one: assert property (
		go && op == 8'h0b |=> !pready ##1 pready)
		else $error("and literal busy length wrong");
	chk_add_two: assert property (
		go && op[7:2] == 6'h08 |=> !pready[*2] ##1 pready)
		else $error("add busy length wrong");
	chk_comp_two: assert property (
		go && op[7:2] == 6'h07 |=> !pready[*2] ##1 pready)
		else $error("complement busy length wrong");
	chk_skip_len: assert property (
		go && op[7:1] == 7'h31 |=> !pready[*2] ##[1:3] pready)
		else $error("compare busy length wrong");
	chk_ready_rst: assert property (
		$fell(reset) |-> pready && !pslverr)
		else $error("not idle after reset");
	chk_bad_addr: assert property (
		psel && penable && paddr[31:8] != 0 |-> pslverr)
		else $error("unmapped access not refused");
	chk_status_bits: assert property (
		rd && paddr == 32'hc |-> prdata[31:5] == 0)
		else $error("status upper bits set");
	chk_ctrl_bits: assert property (
		rd && paddr == 32'h0 |-> prdata[31:7] == 0 && prdata[5:1] == 0)
		else $error("control unused bits set");
	cover property (go && op == 8'h0b);
	cover property (go && op[7:1] == 7'h31 ##4 pready);
	cover property (psel && penable && pslverr);
endmodule : byte_alu_props
bind byte_alu byte_alu_props byte_alu_props_inst (.ref_clk, .reset, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
`default_nettype wire

// ==== byte_alu_tb.sv ====
// testbench: random instruction runs against an integer model
`default_nettype none
module byte_alu_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, e;
	logic [31:0] paddr, pwdata, prdata, q;
	logic [7:0] w, b, f, k, res, nw, nb;
	logic [4:0] st, nst;
	logic [3:0] bk;
	logic [11:0] ix, ad;
	logic [8:0] s;
	logic [15:0] ins;
	logic d, a, x, tw, skip;
	int i, cyc, r, mismatches, n_compared;
	logic [31:0] exp_q[$];
	byte_alu byte_alu_inst (.ref_clk, .reset, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr);
	initial begin
		ref_clk = 0;
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic print_verdict;
		if (mismatches == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict
	task automatic check(input string nm, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// ****************************************
	// apb master: hold until pready sampled
	// ****************************************
	task automatic bus(input logic wr, input logic [31:0] ad_, dt);
		int n;
		n = 0;
		psel <= 1;
		pwrite <= wr;
		paddr <= ad_;
		pwdata <= dt;
		@(posedge ref_clk);
		penable <= 1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge ref_clk);
		if (n >= 50) begin
			mismatches++;
			print_verdict;
		end
	endtask : bus
	initial begin
		{psel, penable, pwrite, paddr, pwdata} <= '0;
		reset <= 1;
		r = $urandom(70098);
		repeat (8) @(posedge ref_clk);
		reset <= 0;
		@(posedge ref_clk);
		bus(0, 32'h0, 32'h0);
		check("ctrl", q, 32'h0);
		bus(1, 32'h100, 32'h41);
		check("err", {31'h0, e}, 32'h1);
		bus(0, 32'h140, 32'h0);
		check("err rd", {31'h0, e}, 32'h1);
		check("err data", q, 32'h0);
		bus(0, 32'h0, 32'h0);
		check("ctrl kept", q, 32'h0);
		for (i = 0; i < 96; i++) begin
			{w, b, f, k, st, bk, ix, d, a, x, tw} = 57'({$urandom, $urandom});
			if (i % 8 == 2) b = w;
			if (i % 16 == 5) f = 8'h5f;
			if (i % 16 == 9) f = 8'h60;
			bus(1, 32'h0, {25'h0, x, 5'h0, tw});
			bus(1, 32'h10, {28'h0, bk});
			bus(1, 32'h14, {20'h0, ix});
			bus(1, 32'h8, {24'h0, w});
			bus(1, 32'hc, {27'h0, st});
			ad = a ? {bk, f} : (x && f <= 8'h5f) ? ix + 12'(f) :
				f < 8'h80 ? {4'h0, f} : {4'hf, f};
			bus(1, 32'h18, {20'h0, ad});
			bus(1, 32'h1c, {24'h0, b});
			{nw, nb, nst, skip, cyc} = {w, b, st, 1'b0, 32'd1};
			case (i % 4)
				0: begin
					ins = {6'h08, d, a, f};
					s = w + b + st[0];
					res = s[7:0];
					nst = {res[7], w[7] == b[7] && res[7] != w[7], res == 0,
						5'(w[3:0]) + b[3:0] + st[0] > 15, s[8]};
				end
				1: begin
					ins = {6'h07, d, a, f};
					res = ~b;
					nst = {res[7], st[3], res == 0, st[1:0]};
				end
				2: begin
					ins = {7'h31, a, f};
					skip = b == w;
					cyc = skip ? 2 + tw : 1;
				end
				default: begin
					ins = {8'h0b, k};
					res = w & k;
					nst = {res[7], st[3], res == 0, st[1:0]};
				end
			endcase
			if (i % 4 == 3 || i % 4 < 2 && !d) nw = res;
			else if (i % 4 < 2) nb = res;
			exp_q.push_back({24'h0, nw});
			exp_q.push_back({27'h0, nst});
			exp_q.push_back({24'h0, nb});
			exp_q.push_back({26'h0, 2'(cyc), 2'h0, skip, 1'b0});
			bus(1, 32'h4, {16'h0, ins});
			bus(0, 32'h8, 32'h0);
			check("w", q, exp_q.pop_front());
			bus(0, 32'hc, 32'h0);
			check("st", q, exp_q.pop_front());
			bus(1, 32'h18, {20'h0, ad});
			bus(0, 32'h1c, 32'h0);
			check("ram", q, exp_q.pop_front());
			bus(0, 32'h20, 32'h0);
			check("exec", q & 32'h32, exp_q.pop_front());
		end
		// ****************************************
		// mid-run reset: registers back to zero
		// ****************************************
		reset <= 1;
		repeat (2) @(posedge ref_clk);
		reset <= 0;
		@(posedge ref_clk);
		bus(0, 32'h0, 32'h0);
		check("ctrl rst", q, 32'h0);
		bus(0, 32'h8, 32'h0);
		check("w rst", q, 32'h0);
		bus(0, 32'h20, 32'h0);
		check("exec rst", q, 32'h0);
		print_verdict;
	end
endmodule : byte_alu_tb
`default_nettype wire
